// *** rtl/ihb_host_core.sv ***
// Two-wire host core: baud generator, byte engine, bus state monitor, Wishbone registers
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ihb_host_core #(
  parameter int TMO_W = 12
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Bus lines, open drain
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // Pad options
  output logic [1:0] o_data_hold_time_sel,
  output logic o_data_setup_time_sel,
  output logic o_fast_plus_enable
);
  if (TMO_W < 12 || (1 << TMO_W) <= ihb_pkg::TMO3_CYC) begin : g_chk
    $error("TMO_W too small for the longest time-out");
  end

  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] shared_control_a_q, host_control_a_q, host_baud_reg_q, host_data_reg_q;
  logic ackact_q, client_en_q, client_match_q;
  logic [6:0] client_own_address_q;
  logic scl_s1_q, scl_s2_q, scl_p_q, sda_s1_q, sda_s2_q, sda_p_q;
  logic start_det, stop_det, scl_rise;
  ihb_pkg::ihb_state_e st_q;
  logic [1:0] phase_q, bus_q;
  logic [8:0] cnt_q, tx_q, own_q, half;
  logic [7:0] rx_q;
  logic [3:0] nbits_q;
  logic hi_seen_q, mode_rx_q, is_addr_q, rw_q, stop_after_q, sda_low_q;
  logic rif_q, wif_q, rxack_q, arb_q, berr_q;
  logic [TMO_W-1:0] tmo_q, tmo_lim;
  logic [3:0] cl_cnt_q;
  logic [7:0] cl_sr_q;
  logic cl_act_q;
  logic req, wr, en, wr_stat, wr_addr, wr_data, wr_cmd, force_idle;
  logic cnt_last, lose, berr, byte_end, cont_rd, set_wif, set_rif, tmo_exp;
  ihb_pkg::ihb_hstat_s stat;

  assign req = i_wb_cyc & i_wb_stb;
  assign wr = req & i_wb_we & ack_q & i_wb_sel[0];
  assign en = host_control_a_q[ihb_pkg::HOST_EN_BIT]; // RL2
  assign wr_stat = wr & (i_wb_adr == ihb_pkg::ADR_HOST_STATUS_REG);
  assign wr_addr = wr & (i_wb_adr == ihb_pkg::ADR_HOST_TARGET_ADDRESS);
  assign wr_data = wr & (i_wb_adr == ihb_pkg::ADR_HOST_DATA_REG);
  assign wr_cmd = wr & (i_wb_adr == ihb_pkg::ADR_HOST_CONTROL_B) & (i_wb_dat[1] == 1'b1);
  assign force_idle = wr_stat & (i_wb_dat[1:0] == ihb_pkg::BUS_IDLE); // RL3

  // Bus slave: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;

  assign stat = '{rif: rif_q, wif: wif_q, clkhold: (st_q == ihb_pkg::S_HOLD) & (rif_q | wif_q),
                  rxack: rxack_q, arblost: arb_q, buserr: berr_q, bus_state_field: bus_q}; // RL8

  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      rdat_q <= 32'h0;
    else if (req & ~ack_q)
    begin
      unique case (i_wb_adr)
        ihb_pkg::ADR_SHARED_CONTROL_A: rdat_q <= {24'h0, shared_control_a_q};
        ihb_pkg::ADR_HOST_CONTROL_A: rdat_q <= {24'h0, host_control_a_q};
        ihb_pkg::ADR_HOST_CONTROL_B: rdat_q <= {29'h0, ackact_q, 2'h0};
        ihb_pkg::ADR_HOST_STATUS_REG: rdat_q <= {24'h0, stat};
        ihb_pkg::ADR_HOST_BAUD_REG: rdat_q <= {24'h0, host_baud_reg_q};
        ihb_pkg::ADR_HOST_DATA_REG: rdat_q <= {24'h0, host_data_reg_q};
        ihb_pkg::ADR_CLIENT_CONTROL_A: rdat_q <= {31'h0, client_en_q};
        ihb_pkg::ADR_CLIENT_OWN_ADDRESS: rdat_q <= {24'h0, client_own_address_q, 1'b0};
        ihb_pkg::ADR_CLIENT_STATUS: rdat_q <= {31'h0, client_match_q};
        default: rdat_q <= 32'h0;
      endcase
    end
  assign o_wb_dat = rdat_q;
  assign o_wb_ack = ack_q;

  // Software registers; pad options are only meant to change while disabled (RL1, RL4)
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      shared_control_a_q <= 8'h00;
      host_control_a_q <= 8'h00;
      host_baud_reg_q <= ihb_pkg::BAUD_RESET;
      ackact_q <= 1'b0;
      client_en_q <= 1'b0;
      client_own_address_q <= 7'h00;
    end
    else if (wr)
    begin
      if (i_wb_adr == ihb_pkg::ADR_SHARED_CONTROL_A)
        shared_control_a_q <= i_wb_dat[7:0];
      if (i_wb_adr == ihb_pkg::ADR_HOST_CONTROL_A)
        host_control_a_q <= i_wb_dat[7:0];
      if (i_wb_adr == ihb_pkg::ADR_HOST_BAUD_REG)
        host_baud_reg_q <= i_wb_dat[7:0];
      if (i_wb_adr == ihb_pkg::ADR_HOST_CONTROL_B)
        ackact_q <= i_wb_dat[ihb_pkg::ACKACT_BIT];
      if (i_wb_adr == ihb_pkg::ADR_CLIENT_CONTROL_A)
        client_en_q <= i_wb_dat[0];
      if (i_wb_adr == ihb_pkg::ADR_CLIENT_OWN_ADDRESS)
        client_own_address_q <= i_wb_dat[7:1];
    end
  assign o_fast_plus_enable = shared_control_a_q[ihb_pkg::FAST_PLUS_BIT];
  assign o_data_hold_time_sel = shared_control_a_q[ihb_pkg::HOLD_SEL_LSB +: 2];
  assign o_data_setup_time_sel = shared_control_a_q[ihb_pkg::SETUP_SEL_BIT];

  // Line synchronisers and condition detectors
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_p_q} <= 3'h7;
    end
    else
    begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= {i_scl, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_p_q} <= {i_sda, sda_s1_q, sda_s2_q};
    end
  assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q; // RL15
  assign stop_det = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q; // RL15
  assign scl_rise = scl_s2_q & ~scl_p_q;

  // Engine events
  assign half = {1'b0, host_baud_reg_q} + ihb_pkg::HALF_OFFSET; // RL10 RL12
  assign cnt_last = (cnt_q == half - 9'h001);
  // Collision: released a one but the line reads low
  assign lose = (st_q == ihb_pkg::S_HIGH) & scl_s2_q & ~hi_seen_q & own_q[8] & tx_q[8]
              & ~sda_s2_q; // RL21
  assign berr = (start_det | stop_det) & ((st_q == ihb_pkg::S_LOW) | (st_q == ihb_pkg::S_HIGH)
              | (st_q == ihb_pkg::S_HOLD));
  assign byte_end = (st_q == ihb_pkg::S_HIGH) & hi_seen_q & cnt_last & (nbits_q == 4'h1);
  assign cont_rd = byte_end & ~mode_rx_q & is_addr_q & rw_q & ~rx_q[0];
  assign set_wif = (byte_end & ~mode_rx_q & ~cont_rd) | lose | berr; // RL6
  assign set_rif = byte_end & mode_rx_q & ~stop_after_q; // RL6

  // Byte engine
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      st_q <= ihb_pkg::S_IDLE;
      {phase_q, cnt_q, tx_q, own_q, rx_q, nbits_q} <= '0;
      {hi_seen_q, mode_rx_q, is_addr_q, rw_q, stop_after_q} <= 5'h0;
      host_data_reg_q <= 8'h00;
    end
    else if (!en || lose || berr)
      st_q <= ihb_pkg::S_IDLE;
    else
    begin
      cnt_q <= cnt_q + 9'h001;
      unique case (st_q)
        ihb_pkg::S_IDLE, ihb_pkg::S_WAIT:
          if (st_q == ihb_pkg::S_WAIT && bus_q == ihb_pkg::BUS_IDLE)
          begin
            st_q <= ihb_pkg::S_START;
            {phase_q, cnt_q} <= '0;
          end
          else if (wr_addr)
            st_q <= ihb_pkg::S_WAIT; // RL22
        ihb_pkg::S_START:
          if (phase_q == 2'h0 && !scl_s2_q)
            cnt_q <= '0;
          else if (cnt_last)
          begin
            cnt_q <= '0;
            phase_q <= 2'h1;
            if (phase_q == 2'h1)
              st_q <= ihb_pkg::S_LOW;
          end
        ihb_pkg::S_LOW:
          if (cnt_last)
          begin
            st_q <= ihb_pkg::S_HIGH;
            cnt_q <= '0;
            hi_seen_q <= 1'b0;
          end
        ihb_pkg::S_HIGH:
          if (!hi_seen_q)
          begin
            cnt_q <= '0; // RL11
            if (scl_s2_q)
            begin
              hi_seen_q <= 1'b1;
              rx_q <= {rx_q[6:0], sda_s2_q};
            end
          end
          else if (cnt_last)
          begin
            cnt_q <= '0;
            st_q <= ihb_pkg::S_LOW;
            if (nbits_q != 4'h1)
            begin
              tx_q <= {tx_q[7:0], 1'b1};
              own_q <= {own_q[7:0], 1'b0};
              nbits_q <= nbits_q - 4'h1;
            end
            else if (stop_after_q)
            begin
              st_q <= ihb_pkg::S_STOP;
              phase_q <= 2'h0;
            end
            else if (cont_rd)
            begin
              {tx_q, own_q, nbits_q, mode_rx_q, is_addr_q} <= {9'h1ff, 9'h000, 4'h8, 2'b10};
            end
            else
            begin
              st_q <= ihb_pkg::S_HOLD;
              if (mode_rx_q)
                host_data_reg_q <= rx_q;
            end
          end
        ihb_pkg::S_HOLD:
        begin
          cnt_q <= '0;
          phase_q <= 2'h0;
          if (wr_addr)
            st_q <= ihb_pkg::S_START;
          else if (wr_data && !mode_rx_q)
            st_q <= ihb_pkg::S_LOW;
          else if (wr_cmd && (mode_rx_q || i_wb_dat[1:0] == ihb_pkg::CMD_STOP))
            st_q <= (mode_rx_q ? ihb_pkg::S_LOW : ihb_pkg::S_STOP);
        end
        ihb_pkg::S_STOP:
          if (phase_q == 2'h1 && !scl_s2_q)
            cnt_q <= '0;
          else if (cnt_last)
          begin
            cnt_q <= '0;
            phase_q <= phase_q + 2'h1;
            if (phase_q == 2'h2)
              st_q <= ihb_pkg::S_IDLE; // RL20
          end
        default: st_q <= ihb_pkg::S_IDLE;
      endcase
      // Loads for new transfers
      if (wr_addr && (st_q == ihb_pkg::S_IDLE || st_q == ihb_pkg::S_HOLD))
      begin
        {tx_q, own_q, nbits_q} <= {i_wb_dat[7:0], 1'b1, 9'h1fe, 4'h9};
        {mode_rx_q, is_addr_q, rw_q, stop_after_q} <= {2'b01, i_wb_dat[0], 1'b0};
      end
      else if (st_q == ihb_pkg::S_HOLD && wr_data && !mode_rx_q)
      begin
        {tx_q, own_q, nbits_q, is_addr_q} <= {i_wb_dat[7:0], 1'b1, 9'h1fe, 4'h9, 1'b0};
        host_data_reg_q <= i_wb_dat[7:0];
      end
      else if (st_q == ihb_pkg::S_HOLD && wr_cmd && mode_rx_q)
      begin
        // Acknowledge choice written together with the command is the one sent
        {tx_q, own_q} <= {i_wb_dat[ihb_pkg::ACKACT_BIT], 8'hff, 9'h100};
        stop_after_q <= (i_wb_dat[1:0] == ihb_pkg::CMD_STOP);
        nbits_q <= (i_wb_dat[1:0] == ihb_pkg::CMD_STOP) ? 4'h1 : 4'h9;
      end
    end

  // Data line drive changes two cycles into the low phase so it never changes under SCL high
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      sda_low_q <= 1'b0;
    else if (!en || lose || berr || st_q == ihb_pkg::S_IDLE || st_q == ihb_pkg::S_WAIT)
      sda_low_q <= 1'b0;
    else if (st_q == ihb_pkg::S_START)
      sda_low_q <= (phase_q == 2'h1);
    else if (st_q == ihb_pkg::S_LOW && cnt_q == 9'h001)
      sda_low_q <= ~tx_q[8];
    else if (st_q == ihb_pkg::S_STOP && cnt_q == 9'h001)
      sda_low_q <= (phase_q != 2'h2);

  assign o_scl_oe = (st_q == ihb_pkg::S_LOW) | ((st_q == ihb_pkg::S_STOP) & (phase_q == 2'h0))
                  | ((st_q == ihb_pkg::S_HOLD) & (rif_q | wif_q)); // RL7
  assign o_sda_oe = sda_low_q;
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;

  // Status flags; a hardware set wins over a software clear
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      {rif_q, wif_q, rxack_q, arb_q, berr_q} <= 5'h0;
    else if (!en)
      {rif_q, wif_q, rxack_q, arb_q, berr_q} <= 5'h0;
    else
    begin
      wif_q <= set_wif | (wif_q & ~((wr_stat & i_wb_dat[ihb_pkg::CLR_WIF_BIT]) | wr_data
               | wr_addr | wr_cmd)); // RL7
      rif_q <= set_rif | (rif_q & ~((wr_stat & i_wb_dat[ihb_pkg::CLR_RIF_BIT]) | wr_data
               | wr_addr | wr_cmd)); // RL7
      arb_q <= lose | berr | (arb_q & ~(wr_stat & i_wb_dat[ihb_pkg::CLR_ARB_BIT] | wr_addr));
      berr_q <= berr | (berr_q & ~(wr_stat & i_wb_dat[ihb_pkg::CLR_BERR_BIT] | wr_addr));
      if (byte_end && !mode_rx_q)
        rxack_q <= rx_q[0];
    end

  // Inactive bus time-out
  always_comb
  begin
    unique case (host_control_a_q[ihb_pkg::TMO_LSB +: 2])
      2'h1: tmo_lim = TMO_W'(ihb_pkg::TMO1_CYC);
      2'h2: tmo_lim = TMO_W'(ihb_pkg::TMO2_CYC);
      2'h3: tmo_lim = TMO_W'(ihb_pkg::TMO3_CYC);
      default: tmo_lim = '0;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      tmo_q <= '0;
    else if (!en || tmo_lim == '0 || scl_s2_q != scl_p_q || sda_s2_q != sda_p_q)
      tmo_q <= '0;
    else if (tmo_q != tmo_lim)
      tmo_q <= tmo_q + 1'b1;
  assign tmo_exp = (tmo_lim != '0) & (tmo_q == tmo_lim); // RL18

  // Bus state monitor, running whenever the host is enabled
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      bus_q <= ihb_pkg::BUS_UNKNOWN; // RL16
    else if (!en)
      bus_q <= ihb_pkg::BUS_UNKNOWN; // RL16 RL14
    else if (force_idle)
      bus_q <= ihb_pkg::BUS_IDLE; // RL3
    else if (lose || berr)
      bus_q <= stop_det ? ihb_pkg::BUS_IDLE : ihb_pkg::BUS_BUSY; // RL21
    else if (stop_det)
      bus_q <= ihb_pkg::BUS_IDLE; // RL17 RL19 RL20
    else if (start_det && st_q == ihb_pkg::S_START)
      bus_q <= ihb_pkg::BUS_OWNER; // RL20
    else if (start_det && bus_q == ihb_pkg::BUS_IDLE)
      bus_q <= ihb_pkg::BUS_BUSY; // RL19
    else if (tmo_exp && (bus_q == ihb_pkg::BUS_UNKNOWN || bus_q == ihb_pkg::BUS_BUSY))
      bus_q <= ihb_pkg::BUS_IDLE; // RL18 RL19

  // Bit counter and passive client address match
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      {cl_act_q, cl_cnt_q, cl_sr_q, client_match_q} <= '0;
    else
    begin
      if (start_det)
        {cl_act_q, cl_cnt_q} <= {1'b1, 4'h0}; // RL15
      else if (stop_det)
        cl_act_q <= 1'b0;
      else if (scl_rise && cl_act_q)
      begin
        cl_sr_q <= {cl_sr_q[6:0], sda_s2_q};
        cl_cnt_q <= cl_cnt_q + 4'h1;
        if (cl_cnt_q == 4'h7)
          cl_act_q <= 1'b0;
      end
      client_match_q <= (client_en_q & scl_rise & cl_act_q & (cl_cnt_q == 4'h7)
                        & (cl_sr_q[6:0] == client_own_address_q))
                        | (client_match_q & ~(wr & i_wb_dat[0]
                        & (i_wb_adr == ihb_pkg::ADR_CLIENT_STATUS))); // RL5
    end

  // Assertions
  sequence seq_own_stop;
    (st_q == ihb_pkg::S_STOP && phase_q == 2'h2) ##1 (st_q == ihb_pkg::S_IDLE);
  endsequence
  AST_FORCE_IDLE: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL3
    force_idle && en |=> bus_q == ihb_pkg::BUS_IDLE) else $error("force to idle ignored");
  AST_NO_OTHER_FORCE: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL3
    wr_stat && !force_idle && en && !start_det && !stop_det && !tmo_exp && !lose
    |=> $stable(bus_q)) else $error("bus state forced to non-idle");
  AST_DISABLED_UNKNOWN: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL16
    !en |=> bus_q == ihb_pkg::BUS_UNKNOWN) else $error("bus state not unknown when off");
  AST_STOP_IDLE: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL17
    stop_det && en |=> bus_q == ihb_pkg::BUS_IDLE) else $error("stop did not give idle");
  AST_HOLD_SCL: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL7
    set_wif && byte_end |=> o_scl_oe [*2]) else $error("scl not held after byte");
  AST_LOSE_BUSY: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL21
    lose && en && !force_idle && !stop_det
    |=> bus_q == ihb_pkg::BUS_BUSY && arb_q && !o_scl_oe) else $error("lost arb not busy");
  AST_WAIT_BUSY: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL22
    st_q == ihb_pkg::S_WAIT && bus_q != ihb_pkg::BUS_IDLE && en |=> st_q == ihb_pkg::S_WAIT)
    else $error("start issued while bus not idle");
  AST_HIGH_WAIT: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL11
    st_q == ihb_pkg::S_HIGH && !hi_seen_q && !scl_s2_q && en |=> st_q == ihb_pkg::S_HIGH)
    else $error("high phase ended before scl high");
  AST_LOW_LEN: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL12
    st_q == ihb_pkg::S_LOW && cnt_last && en && !berr |=> st_q == ihb_pkg::S_HIGH && !o_scl_oe)
    else $error("low phase length wrong");
  AST_OWN_STOP_IDLE: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL20
    seq_own_stop |-> ##[0:4] (bus_q == ihb_pkg::BUS_IDLE || !en))
    else $error("own stop did not give idle");
endmodule : ihb_host_core
`default_nettype wire

// *** rtl/ihb_pkg.sv ***
// Constants, register map and carrier types for the two-wire host core
// Functional notes
// (RL1) Software sets hold-time and fast-plus options before enabling; not changed while enabled.
// (RL2) Writing one to host enable starts the host and its bus state machine.
// (RL3) Writing 0x1 to the bus state field forces Idle; nothing else forceable.
// (RL4) Software sets setup option, then own address, then client enable.
// (RL5) Enabled client stays passive until Start plus matching address.
// (RL6) Separate write and read byte-done flags, pollable, one per byte.
// (RL7) Any host flag set holds SCL low; clearing it releases SCL. Code: held only in the hold state, not after arbitration loss or bus error.
// (RL8) Status shows ack received, bus error, arbitration lost, clock hold, bus state.
// (RL9) Software keeps SCL at or below 100 kHz, 400 kHz or 1 MHz.
// (RL10) SCL low and high durations come from the baud value.
// (RL11) Equal low and high halves; high count starts only once SCL seen high.
// (RL12) SCL period is ten plus twice baud cycles plus rise time.
// (RL13) Software checks low time against 4700, 1300 or 500 ns minimums.
// (RL14) Bus monitor runs whenever host enabled, in every sleep mode.
// (RL15) Monitor uses Start, Stop, collision, time-out detectors and a bit counter.
// (RL16) Bus state is Unknown after enable, reset and disable.
// (RL17) Without forcing, first detected Stop moves the monitor to Idle.
// (RL18) Nonzero time-out setting moves the monitor to Idle on expiry. Code: only from Unknown or Busy, not from Owner.
// (RL19) External Start while Idle gives Busy; Stop or time-out returns Idle.
// (RL20) Own Start while Idle gives Owner; own Stop returns Idle.
// (RL21) Collision while owning loses arbitration; Busy until Stop.
// (RL22) A transaction requested while Busy waits for Idle before Start.
// (RL23) Bus state encoding: Unknown 0, Idle 1, Busy 2, Owner 3.
package ihb_pkg;
  // Register byte addresses, one word each
  localparam logic [7:0] ADR_SHARED_CONTROL_A = 8'h00;
  localparam logic [7:0] ADR_HOST_CONTROL_A = 8'h04;
  localparam logic [7:0] ADR_HOST_CONTROL_B = 8'h08;
  localparam logic [7:0] ADR_HOST_STATUS_REG = 8'h0c;
  localparam logic [7:0] ADR_HOST_BAUD_REG = 8'h10;
  localparam logic [7:0] ADR_HOST_TARGET_ADDRESS = 8'h14;
  localparam logic [7:0] ADR_HOST_DATA_REG = 8'h18;
  localparam logic [7:0] ADR_CLIENT_CONTROL_A = 8'h1c;
  localparam logic [7:0] ADR_CLIENT_OWN_ADDRESS = 8'h20;
  localparam logic [7:0] ADR_CLIENT_STATUS = 8'h24;
  // Field positions
  localparam int FAST_PLUS_BIT = 1;
  localparam int HOLD_SEL_LSB = 2;
  localparam int SETUP_SEL_BIT = 4;
  localparam int HOST_EN_BIT = 0;
  localparam int TMO_LSB = 2;
  localparam int ACKACT_BIT = 2;
  localparam int CLR_RIF_BIT = 7;
  localparam int CLR_WIF_BIT = 6;
  localparam int CLR_ARB_BIT = 3;
  localparam int CLR_BERR_BIT = 2;
  // Values
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [8:0] HALF_OFFSET = 9'h005;
  localparam logic [1:0] CMD_RECV = 2'h2;
  localparam logic [1:0] CMD_STOP = 2'h3;
  localparam logic [1:0] BUS_UNKNOWN = 2'h0; // RL23
  localparam logic [1:0] BUS_IDLE = 2'h1; // RL23
  localparam logic [1:0] BUS_BUSY = 2'h2; // RL23
  localparam logic [1:0] BUS_OWNER = 2'h3; // RL23
  // Inactive bus time-outs
  localparam int CLK_PERIOD_NS = 50;
  localparam int TMO1_US = 50;
  localparam int TMO2_US = 100;
  localparam int TMO3_US = 200;
  localparam int TMO1_CYC = TMO1_US * 1000 / CLK_PERIOD_NS;
  localparam int TMO2_CYC = TMO2_US * 1000 / CLK_PERIOD_NS;
  localparam int TMO3_CYC = TMO3_US * 1000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic rif;
    logic wif;
    logic clkhold;
    logic rxack;
    logic arblost;
    logic buserr;
    logic [1:0] bus_state_field;
  } ihb_hstat_s;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_WAIT = 7'b0000010,
    S_START = 7'b0000100,
    S_LOW = 7'b0001000,
    S_HIGH = 7'b0010000,
    S_HOLD = 7'b0100000,
    S_STOP = 7'b1000000
  } ihb_state_e;
endpackage : ihb_pkg

// *** testbench/ihb_client_model.sv ***
// Behavioural client on the two-wire bus: acks its address and writes, sends a fixed byte
`timescale 1ns/1ns
`default_nettype none
module ihb_client_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // Resolved bus lines
  input wire logic i_scl,
  input wire logic i_sda,
  // Byte returned on reads
  input wire logic [7:0] i_tx,
  // Pull SDA low
  output logic o_sda_oe
);
  int cnt;
  logic hdr, sel, rd;
  logic [7:0] sh;
  initial
  begin
    cnt = 0;
    hdr = 0;
    sel = 0;
    rd = 0;
    sh = 8'h00;
    o_sda_oe = 1'h0;
  end
  // Start or stop: both end any transfer in progress
  always @(i_sda)
    if (i_scl)
    begin
      cnt = 0;
      hdr = 1'h1;
      sel = 1'h0;
      o_sda_oe = 1'h0;
    end
  always @(posedge i_scl)
  begin
    if (cnt < 8) sh = {sh[6:0], i_sda};
    // A not-acknowledge from the host ends our sending
    if (cnt == 8 && rd && !hdr && i_sda) sel = 1'h0;
    cnt++;
  end
  // Data changes only while SCL is low
  always @(negedge i_scl)
    if (cnt == 8)
    begin
      if (hdr) {sel, rd} = {sh[7:1] == ADDR, sh[0]};
      o_sda_oe = sel & (hdr | !rd);
    end
    else
    begin
      if (cnt == 9) {cnt, hdr} = {32'h0, 1'h0};
      o_sda_oe = sel & rd & !hdr & !i_tx[7 - cnt];
    end
endmodule : ihb_client_model
`default_nettype wire

// *** testbench/ihb_host_core_test.sv ***
// Register-level bench for the two-wire host core
`timescale 1ns/1ns
`default_nettype none
module ihb_host_core_test;
  logic clk, nrst, cyc, stb, we, t_scl, t_sda;
  logic [7:0] adr;
  logic [31:0] wd, q;
  logic [3:0] sel;
  wire logic [31:0] rdat;
  wire logic [1:0] hold;
  wire logic ack, scl_oe, sda_oe, m_sda, fp, su, scl_o, sda_o;
  // Wired-AND with pull-ups
  wire logic scl = !(scl_oe | t_scl);
  wire logic sda = !(sda_oe | t_sda | m_sda);
  int mismatches, checks, cyc_n, lo;
  ihb_host_core u_dut (.i_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wd), .i_wb_sel(sel), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_scl(scl), .o_scl(scl_o), .o_scl_oe(scl_oe), .i_sda(sda),
    .o_sda(sda_o), .o_sda_oe(sda_oe), .o_data_hold_time_sel(hold),
    .o_data_setup_time_sel(su), .o_fast_plus_enable(fp));
  ihb_client_model u_cli (.i_scl(scl), .i_sda(sda), .i_tx(8'ha5), .o_sda_oe(m_sda));
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
    cyc_n <= cyc_n + 1;
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d);
  endtask : wr
  // Reads until the masked value matches; a value that is already right costs one read
  task poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v, input string n);
    int i;
    i = 0;
    do
    begin
      wb(1'h0, a, 32'h0);
      i++;
    end
    while (i < 400 && (q[7:0] & m) !== v);
    chk(q[7:0] & m, v, n);
  endtask : poll
  task w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  // Foreign host line step: half of a 400 ns link period
  task lk(input logic c, input logic d);
    @(posedge clk);
    t_scl <= c;
    t_sda <= d;
    w(3);
  endtask : lk
  task fstart;
    lk(1'h0, 1'h1);
    lk(1'h1, 1'h1);
  endtask : fstart
  task fstop;
    lk(1'h1, 1'h1);
    lk(1'h0, 1'h1);
    lk(1'h0, 1'h0);
  endtask : fstop
  // Whole scenario; a watchdog branch races it
  task run_tests;
    w(3);
    nrst <= 1'h1;
    poll(8'h0c, 8'hff, 8'h00, "status");
    wr(8'h00, 32'h1e);
    w(1);
    chk({fp, hold, su}, 4'hf, "pads");
    chk({scl_o, sda_o}, 2'h0, "drive_level");
    wr(8'h10, 32'h05);
    wr(8'h20, 32'h54);
    wr(8'h1c, 32'h01);
    wr(8'h04, 32'h01);
    poll(8'h0c, 8'h03, 8'h00, "state");
    fstop;
    poll(8'h0c, 8'h03, 8'h01, "state");
    fstart;
    poll(8'h0c, 8'h03, 8'h02, "state");
    poll(8'h24, 8'h01, 8'h00, "client");
    wr(8'h14, 32'h54);
    w(40);
    chk(sda_oe, 1'h0, "sda_oe");
    poll(8'h0c, 8'h03, 8'h02, "state");
    fstop;
    poll(8'h0c, 8'h03, 8'h03, "state");
    poll(8'h0c, 8'hff, 8'h63, "status");
    chk(scl, 1'h0, "scl");
    wr(8'h18, 32'h3c);
    @(posedge scl) lo = cyc_n;
    @(posedge scl) chk((cyc_n - lo) inside {[20:24]}, 1'h1, "period");
    poll(8'h0c, 8'hff, 8'h63, "status");
    wr(8'h08, 32'h03);
    poll(8'h0c, 8'h03, 8'h01, "state");
    chk(scl, 1'h1, "scl");
    wr(8'h14, 32'h55);
    poll(8'h0c, 8'hff, 8'ha3, "status");
    poll(8'h18, 8'hff, 8'ha5, "data");
    wr(8'h08, 32'h02);
    poll(8'h0c, 8'hff, 8'ha3, "status");
    poll(8'h18, 8'hff, 8'ha5, "data");
    wr(8'h08, 32'h07);
    poll(8'h0c, 8'h03, 8'h01, "state");
    poll(8'h24, 8'h01, 8'h01, "client");
    wr(8'h24, 32'h01);
    poll(8'h24, 8'h01, 8'h00, "client");
    wr(8'h14, 32'hfe);
    @(negedge scl);
    @(posedge clk) t_sda <= 1'h1;
    poll(8'h0c, 8'h4b, 8'h4a, "arb");
    lk(1'h0, 1'h0);
    poll(8'h0c, 8'h03, 8'h01, "state");
    wr(8'h0c, 32'h4c);
    wr(8'h04, 32'h00);
    poll(8'h0c, 8'h03, 8'h00, "state");
    wr(8'h04, 32'h01);
    poll(8'h0c, 8'h03, 8'h00, "state");
    wr(8'h0c, 32'h02);
    poll(8'h0c, 8'h03, 8'h00, "state");
    wr(8'h0c, 32'h01);
    poll(8'h0c, 8'h03, 8'h01, "state");
    wr(8'h04, 32'h05);
    fstart;
    w(800);
    poll(8'h0c, 8'h03, 8'h02, "state");
    poll(8'h0c, 8'h03, 8'h01, "state");
    fstop;
  endtask : run_tests
  initial
  begin
    {nrst, cyc, stb, we, t_scl, t_sda, adr, wd, sel} = '0;
    {mismatches, checks, lo} = '0;
    fork
      run_tests;
      begin
        repeat (40000) @(posedge clk);
        mismatches++;
      end
    join_any
    report_and_stop;
  end
endmodule : ihb_host_core_test
`default_nettype wire
